/* logic/bcbm_pkg.sv */
// bcbm_pkg: register map, field positions, reset values and codes
// for the bus cycle breakpoint matcher.
// assumes a 32-bit apb bus and 20-bit multiplexed processor bus lines.
package bcbm_pkg;
  // per breakpoint register word offsets, register n sits at n*stride
  localparam logic [7:0] BKPT_STRIDE = 8'h20;
  localparam logic [7:0] BKPT_WORD_MASK = 8'h1f;
  localparam int BKPT_SEL_BIT = 5;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ADDR_A = 8'h04;
  localparam logic [7:0] OFF_ADDR_B = 8'h08;
  localparam logic [7:0] OFF_PART_A = 8'h0c;
  localparam logic [7:0] OFF_PART_B = 8'h10;
  localparam logic [7:0] OFF_AMASK = 8'h14;
  localparam logic [7:0] OFF_DATA = 8'h18;
  // shared registers
  localparam logic [7:0] OFF_HALT_ENABLE_SETTING = 8'h40;
  localparam logic [7:0] OFF_STATUS = 8'h44;
  localparam logic [7:0] OFF_CMD = 8'h48;
  // control word fields
  localparam int F_EXEC = 0;
  localparam int F_ADDR_EN = 1;
  localparam int F_STAT_EN = 2;
  localparam int F_DATA_EN = 3;
  localparam int F_SEG_EN = 4;
  localparam int F_AMODE = 5;
  localparam int F_DMODE = 8;
  localparam int F_PART2 = 11;
  localparam int F_OBJ_WORD = 12;
  localparam int F_STAT_SEL = 16;
  localparam int F_SEG_SEL = 24;
  // range forms
  localparam logic [2:0] MODE_MASK = 3'h0;
  localparam logic [2:0] MODE_UP = 3'h1;
  localparam logic [2:0] MODE_DOWN = 3'h2;
  localparam logic [2:0] MODE_RANGE = 3'h3;
  localparam logic [2:0] MODE_OBJECT = 3'h4;
  // bus status pin codes
  localparam logic [2:0] BUS_ACK = 3'h0;
  localparam logic [2:0] BUS_IO_RD = 3'h1;
  localparam logic [2:0] BUS_IO_WR = 3'h2;
  localparam logic [2:0] BUS_HALT = 3'h3;
  localparam logic [2:0] BUS_FETCH = 3'h4;
  localparam logic [2:0] BUS_MEM_RD = 3'h5;
  localparam logic [2:0] BUS_MEM_WR = 3'h6;
  // halt enable setting, status and command bits
  localparam int H_EN0 = 0;
  localparam int H_EN1 = 1;
  localparam int H_AND = 2;
  localparam int S_RUN = 0;
  localparam int S_HALTING = 1;
  localparam int S_WARN = 2;
  localparam int S_ERR = 3;
  localparam int S_CFG_BAD = 4;
  localparam int S_MATCH0 = 8;
  localparam int C_GO = 0;
  localparam int C_ABORT = 1;
  // reset values: registers don't care and disabled, halt setting off
  localparam logic [31:0] RST_CTRL = 32'h0000_0000;
  localparam logic [31:0] RST_AMASK = 32'h000f_ffff;
  localparam logic [31:0] RST_DATA = 32'h00ff_0000;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [16:0] WINDOW_BYTES = 17'h00400;
  typedef enum logic [2:0] {
    RUN_IDLE = 3'b001,
    RUN_GO = 3'b010,
    RUN_STOP = 3'b100
  } bcbm_run_type;
endpackage : bcbm_pkg

/* logic/bcbm_match_unit.sv */
// bcbm_match_unit: one breakpoint register's compare logic.
// assumes synchronised bus inputs and one-cycle phase events.
`timescale 1ns/1ps
module bcbm_match_unit (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [31:0] ctrl,
  input wire logic [31:0] addr_a,
  input wire logic [31:0] addr_b,
  input wire logic [31:0] part_a,
  input wire logic [31:0] part_b,
  input wire logic [31:0] amask,
  input wire logic [31:0] data_cfg,
  input wire logic [19:0] s_ad,
  input wire logic [2:0] s_status,
  input wire logic [1:0] s_seg,
  input wire logic [19:0] s_exec_addr,
  input wire logic addr_ev,
  input wire logic data_ev,
  input wire logic exec_ev,
  output logic match,
  output logic diff_base,
  output logic over_window,
  output logic mixed
);
  function automatic logic [19:0] phys(input logic [15:0] b,
                                       input logic [15:0] d);
    return {b, 4'h0} + {4'h0, d};
  endfunction : phys

  logic exec, addr_en, stat_en, data_en, seg_en, part2, ranged;
  logic [2:0] amode, dmode;
  logic [15:0] lo1, hi1, lo2, hi2, lo_min, hi_max;
  logic [19:0] ref1, top1, ref2, top2, mask20;
  logic [16:0] span1, span_all;
  logic [7:0] d, dlo, dhi, dmask;
  logic [6:0] stat_sel, stat_now, stat_q;
  logic addr_hit, addr_q, data_hit, seg_hit, exec_hit;

  assign exec = ctrl[bcbm_pkg::F_EXEC];
  assign addr_en = ctrl[bcbm_pkg::F_ADDR_EN];
  assign stat_en = ctrl[bcbm_pkg::F_STAT_EN];
  assign data_en = ctrl[bcbm_pkg::F_DATA_EN];
  assign seg_en = ctrl[bcbm_pkg::F_SEG_EN];
  assign part2 = ctrl[bcbm_pkg::F_PART2];
  assign amode = ctrl[bcbm_pkg::F_AMODE +: 3];
  assign dmode = ctrl[bcbm_pkg::F_DMODE +: 3];
  assign stat_sel = ctrl[bcbm_pkg::F_STAT_SEL +: 7];
  assign ranged = (amode == bcbm_pkg::MODE_RANGE) ||
                  (amode == bcbm_pkg::MODE_OBJECT);
  assign lo1 = addr_a[15:0];
  // object partition: low address plus object size minus one
  assign hi1 = (amode == bcbm_pkg::MODE_OBJECT) ?
               lo1 + {15'h0000, ctrl[bcbm_pkg::F_OBJ_WORD]} :
               addr_b[15:0];
  assign lo2 = part_a[15:0];
  assign hi2 = part_b[15:0];
  assign ref1 = phys(addr_a[31:16], lo1);
  assign top1 = phys(addr_a[31:16], hi1);
  assign ref2 = phys(part_a[31:16], lo2);
  assign top2 = phys(part_a[31:16], hi2);
  assign mask20 = amask[19:0];
  assign lo_min = (part2 && lo2 < lo1) ? lo2 : lo1;
  assign hi_max = (part2 && hi2 > hi1) ? hi2 : hi1;
  assign span1 = {1'b0, hi1} - {1'b0, lo1};
  assign span_all = {1'b0, hi_max} - {1'b0, lo_min};
  // a wider partition must be split over both registers by software
  assign over_window = addr_en && ranged && !exec &&
    (span1 >= bcbm_pkg::WINDOW_BYTES ||
     span_all >= bcbm_pkg::WINDOW_BYTES);
  assign diff_base = addr_en && ranged && part2 && !exec &&
                     (part_a[31:16] != addr_a[31:16]);
  assign mixed = addr_en && (data_en || seg_en) && !exec;

  always_comb begin
    case (amode)
      bcbm_pkg::MODE_MASK: addr_hit = ((s_ad ^ ref1) & ~mask20) == 20'h00000;
      bcbm_pkg::MODE_UP: addr_hit = s_ad >= ref1;
      bcbm_pkg::MODE_DOWN: addr_hit = s_ad <= ref1;
      bcbm_pkg::MODE_RANGE, bcbm_pkg::MODE_OBJECT: addr_hit =
        (s_ad >= ref1 && s_ad <= top1) ||
        (part2 && s_ad >= ref2 && s_ad <= top2);
      default: addr_hit = 1'b0;
    endcase
  end

  // only the low byte carries data; upper reference bits are ignored
  assign d = s_ad[7:0];
  assign dlo = data_cfg[7:0];
  assign dhi = data_cfg[15:8];
  assign dmask = data_cfg[23:16];
  always_comb begin
    case (dmode)
      bcbm_pkg::MODE_MASK: data_hit = ((d ^ dlo) & ~dmask) == 8'h00;
      bcbm_pkg::MODE_UP: data_hit = d >= dlo;
      bcbm_pkg::MODE_DOWN: data_hit = d <= dlo;
      bcbm_pkg::MODE_RANGE: data_hit = d >= dlo && d <= dhi;
      default: data_hit = 1'b0;
    endcase
  end

  always_comb begin
    case (s_status)
      bcbm_pkg::BUS_MEM_RD: stat_now = 7'h01;
      bcbm_pkg::BUS_MEM_WR: stat_now = 7'h02;
      bcbm_pkg::BUS_IO_RD: stat_now = 7'h04;
      bcbm_pkg::BUS_IO_WR: stat_now = 7'h08;
      bcbm_pkg::BUS_FETCH: stat_now = 7'h10;
      bcbm_pkg::BUS_HALT: stat_now = 7'h20;
      bcbm_pkg::BUS_ACK: stat_now = 7'h40;
      default: stat_now = 7'h00;
    endcase
  end

  assign seg_hit = s_seg == ctrl[bcbm_pkg::F_SEG_SEL +: 2];
  assign exec_hit = ((s_exec_addr ^ ref1) & ~mask20) == 20'h00000;

  // address and status are held from address time to data time
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      addr_q <= 1'b0;
      stat_q <= 7'h00;
    end else if (ce && addr_ev) begin
      addr_q <= addr_hit;
      stat_q <= stat_now;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      match <= 1'b0;
    end else if (ce) begin
      if (exec) begin
        match <= exec_ev && exec_hit;
      end else begin
        match <= data_ev && (addr_en || stat_en || data_en || seg_en) &&
          (!addr_en || addr_q) && (!stat_en || |(stat_q & stat_sel)) &&
          (!data_en || data_hit) && (!seg_en || seg_hit);
      end
    end
  end

  default clocking cb @(posedge clock iff ce); endclocking
  default disable iff (!rst_n);
  exec_match_a: assert property (exec && exec_ev && exec_hit |=> match)
    else $error("execution match missed");
  data_only_a: assert property (!exec && data_ev && data_en && !addr_en &&
    !stat_en && !seg_en |=> match == $past(data_hit))
    else $error("data value match wrong");
  up_latch_a: assert property (addr_ev && amode == bcbm_pkg::MODE_UP &&
    s_ad >= ref1 |=> addr_q)
    else $error("upward range not latched");
endmodule : bcbm_match_unit

/* logic/bcbm_top.sv */
// bcbm_top: breakpoint matcher with two breakpoint registers on apb.
// assumes processor bus pins are asynchronous and phase strobes are
// levels lasting at least two clocks; apb master on this clock.
//
// How it works
// - match when every enabled field agrees
// - upward range matches addresses at or above
// - downward range matches addresses at or below
// - masked digits match any value
// - partition over 1K needs both registers
// - object partition spans byte or word size
// - status matches any selected type, order-free
// - five read/write/fetch cycle types selectable
// - halt and interrupt acknowledge also selectable
// - data compares low eight bits at data time
// - data ranges allow all forms except object
// - segment usage compared at data time
// - address at address time, data later
// - illegal and warns on load, blocks launch
// - address with data needs both registers
// - differing partition bases are rejected
// - launch enables registers, contents untouched
// - execution match on queue byte leaving
// - no halt factors selected: only abort halts
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module bcbm_top (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [19:0] bus_ad,
  input wire logic [2:0] bus_status,
  input wire logic [1:0] bus_seg,
  input wire logic addr_time,
  input wire logic data_time,
  input wire logic [19:0] exec_addr,
  input wire logic exec_strobe,
  input wire logic instr_done,
  output logic halt_request,
  output logic emu_running
);
  logic [48:0] pin_raw, sync_a, sync_b;
  logic [3:0] strobe_prev, strobe_rise;
  logic [19:0] s_ad, s_exec_addr;
  logic [2:0] s_status;
  logic [1:0] s_seg;
  logic commit, wr_commit, is_bkpt, is_cfg_addr, go_cmd, abort_cmd;
  logic [7:0] word;
  logic [31:0] bkpt_ctrl [0:1];
  logic [31:0] bkpt_addr_a [0:1];
  logic [31:0] bkpt_addr_b [0:1];
  logic [31:0] bkpt_part_a [0:1];
  logic [31:0] bkpt_part_b [0:1];
  logic [31:0] bkpt_amask [0:1];
  logic [31:0] bkpt_data [0:1];
  logic [2:0] halt_enable_setting;
  logic [1:0] m_hit, exec_k, addr_k, dtime_k, diff_base, over_win, mixed;
  logic [1:0] match_seen;
  logic illegal_and, cfg_bad, hit, load_seen, warn, err, stat_clr;
  logic [31:0] rd_value;
  logic rd_ok;
  bcbm_pkg::bcbm_run_type run_state, next_run_state;

  // every pin goes through two flops; strobes are edge detected after
  assign pin_raw = {bus_ad, bus_status, bus_seg, exec_addr,
                    addr_time, data_time, exec_strobe, instr_done};
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync_a <= '0;
      sync_b <= '0;
      strobe_prev <= 4'h0;
    end else if (ce) begin
      sync_a <= pin_raw;
      sync_b <= sync_a;
      strobe_prev <= sync_b[3:0];
    end
  end
  assign s_ad = sync_b[48:29];
  assign s_status = sync_b[28:26];
  assign s_seg = sync_b[25:24];
  assign s_exec_addr = sync_b[23:4];
  assign strobe_rise = sync_b[3:0] & ~strobe_prev;

  // apb: pready is registered, so every transfer takes one wait state
  assign commit = psel && penable && pready;
  assign wr_commit = commit && pwrite;
  assign word = paddr & bcbm_pkg::BKPT_WORD_MASK;
  assign is_bkpt = paddr < bcbm_pkg::OFF_HALT_ENABLE_SETTING;
  assign is_cfg_addr = paddr <= bcbm_pkg::OFF_HALT_ENABLE_SETTING;
  assign go_cmd = wr_commit && paddr == bcbm_pkg::OFF_CMD &&
                  pwdata[bcbm_pkg::C_GO];
  assign abort_cmd = wr_commit && paddr == bcbm_pkg::OFF_CMD &&
                     pwdata[bcbm_pkg::C_ABORT];
  assign stat_clr = wr_commit && paddr == bcbm_pkg::OFF_STATUS;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_bkpt
      logic sel;
      assign sel = ce && wr_commit && is_bkpt &&
                   paddr[bcbm_pkg::BKPT_SEL_BIT] == gi[0];
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          bkpt_ctrl[gi] <= bcbm_pkg::RST_CTRL;
          bkpt_addr_a[gi] <= bcbm_pkg::RST_WORD;
          bkpt_addr_b[gi] <= bcbm_pkg::RST_WORD;
          bkpt_part_a[gi] <= bcbm_pkg::RST_WORD;
          bkpt_part_b[gi] <= bcbm_pkg::RST_WORD;
          bkpt_amask[gi] <= bcbm_pkg::RST_AMASK;
          bkpt_data[gi] <= bcbm_pkg::RST_DATA;
        end else if (sel) begin
          case (word)
            bcbm_pkg::OFF_CTRL: bkpt_ctrl[gi] <= pwdata;
            bcbm_pkg::OFF_ADDR_A: bkpt_addr_a[gi] <= pwdata;
            bcbm_pkg::OFF_ADDR_B: bkpt_addr_b[gi] <= {16'h0000, pwdata[15:0]};
            bcbm_pkg::OFF_PART_A: bkpt_part_a[gi] <= pwdata;
            bcbm_pkg::OFF_PART_B: bkpt_part_b[gi] <= {16'h0000, pwdata[15:0]};
            bcbm_pkg::OFF_AMASK: bkpt_amask[gi] <= {12'h000, pwdata[19:0]};
            bcbm_pkg::OFF_DATA: bkpt_data[gi] <= {8'h00, pwdata[23:0]};
            default: ;
          endcase
        end
      end
      bcbm_match_unit u_match (
        .clock(clock),
        .rst_n(rst_n),
        .ce(ce),
        .ctrl(bkpt_ctrl[gi]),
        .addr_a(bkpt_addr_a[gi]),
        .addr_b(bkpt_addr_b[gi]),
        .part_a(bkpt_part_a[gi]),
        .part_b(bkpt_part_b[gi]),
        .amask(bkpt_amask[gi]),
        .data_cfg(bkpt_data[gi]),
        .s_ad(s_ad),
        .s_status(s_status),
        .s_seg(s_seg),
        .s_exec_addr(s_exec_addr),
        .addr_ev(strobe_rise[3]),
        .data_ev(strobe_rise[2]),
        .exec_ev(strobe_rise[1]),
        .match(m_hit[gi]),
        .diff_base(diff_base[gi]),
        .over_window(over_win[gi]),
        .mixed(mixed[gi])
      );
      assign exec_k[gi] = bkpt_ctrl[gi][bcbm_pkg::F_EXEC];
      assign addr_k[gi] = bkpt_ctrl[gi][bcbm_pkg::F_ADDR_EN] && !exec_k[gi];
      assign dtime_k[gi] = (bkpt_ctrl[gi][bcbm_pkg::F_DATA_EN] ||
        bkpt_ctrl[gi][bcbm_pkg::F_SEG_EN]) && !exec_k[gi];
    end
  endgenerate

  // writing the halt setting never touches breakpoint contents
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      halt_enable_setting <= 3'h0;
    end else if (ce && wr_commit &&
                 paddr == bcbm_pkg::OFF_HALT_ENABLE_SETTING) begin
      halt_enable_setting <= pwdata[2:0];
    end
  end

  assign illegal_and = halt_enable_setting[bcbm_pkg::H_AND] &&
    (|exec_k || (dtime_k[0] && addr_k[1]));
  assign cfg_bad = illegal_and || |diff_base || |over_win ||
                   |mixed;

  // and needs both registers enabled, else the enabled ones are ored
  always_comb begin
    if (halt_enable_setting[bcbm_pkg::H_AND] &&
        halt_enable_setting[bcbm_pkg::H_EN0] &&
        halt_enable_setting[bcbm_pkg::H_EN1]) begin
      hit = m_hit[0] && m_hit[1];
    end else begin
      hit = (halt_enable_setting[bcbm_pkg::H_EN0] && m_hit[0]) ||
            (halt_enable_setting[bcbm_pkg::H_EN1] && m_hit[1]);
    end
  end

  // load check runs one cycle after the write, on the stored values
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      load_seen <= 1'b0;
      warn <= 1'b0;
      err <= 1'b0;
    end else if (ce) begin
      load_seen <= wr_commit && is_cfg_addr;
      warn <= (load_seen && cfg_bad) ||
        (warn && !(stat_clr && pwdata[bcbm_pkg::S_WARN]));
      err <= (go_cmd && cfg_bad) ||
        (err && !(stat_clr && pwdata[bcbm_pkg::S_ERR]));
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      match_seen <= 2'h0;
    end else if (ce) begin
      match_seen <= m_hit | (go_cmd ? 2'h0 : match_seen);
    end
  end

  always_comb begin
    next_run_state = run_state;
    case (run_state)
      bcbm_pkg::RUN_IDLE: if (go_cmd && !cfg_bad) begin
        next_run_state = bcbm_pkg::RUN_GO;
      end
      bcbm_pkg::RUN_GO: if (abort_cmd || hit) begin
        next_run_state = bcbm_pkg::RUN_STOP;
      end
      bcbm_pkg::RUN_STOP: if (strobe_rise[0]) begin
        next_run_state = bcbm_pkg::RUN_IDLE;
      end
      default: next_run_state = bcbm_pkg::RUN_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      run_state <= bcbm_pkg::RUN_IDLE;
      halt_request <= 1'b0;
      emu_running <= 1'b0;
    end else if (ce) begin
      run_state <= next_run_state;
      halt_request <= next_run_state == bcbm_pkg::RUN_STOP;
      emu_running <= next_run_state != bcbm_pkg::RUN_IDLE;
    end
  end

  always_comb begin
    rd_value = 32'h0000_0000;
    rd_ok = paddr[1:0] == 2'h0;
    if (is_bkpt) begin
      case (word)
        bcbm_pkg::OFF_CTRL: rd_value = bkpt_ctrl[paddr[5]];
        bcbm_pkg::OFF_ADDR_A: rd_value = bkpt_addr_a[paddr[5]];
        bcbm_pkg::OFF_ADDR_B: rd_value = bkpt_addr_b[paddr[5]];
        bcbm_pkg::OFF_PART_A: rd_value = bkpt_part_a[paddr[5]];
        bcbm_pkg::OFF_PART_B: rd_value = bkpt_part_b[paddr[5]];
        bcbm_pkg::OFF_AMASK: rd_value = bkpt_amask[paddr[5]];
        bcbm_pkg::OFF_DATA: rd_value = bkpt_data[paddr[5]];
        default: rd_ok = 1'b0;
      endcase
    end else begin
      case (paddr)
        bcbm_pkg::OFF_HALT_ENABLE_SETTING:
          rd_value = {29'h0000_0000, halt_enable_setting};
        bcbm_pkg::OFF_STATUS: begin
          rd_value[bcbm_pkg::S_RUN] = run_state == bcbm_pkg::RUN_GO;
          rd_value[bcbm_pkg::S_HALTING] = run_state == bcbm_pkg::RUN_STOP;
          rd_value[bcbm_pkg::S_WARN] = warn;
          rd_value[bcbm_pkg::S_ERR] = err;
          rd_value[bcbm_pkg::S_CFG_BAD] = cfg_bad;
          rd_value[bcbm_pkg::S_MATCH0 +: 2] = match_seen;
        end
        bcbm_pkg::OFF_CMD: rd_value = 32'h0000_0000;
        default: rd_ok = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= psel && penable && !pready;
      if (psel && penable && !pready) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_value;
        pslverr <= !rd_ok;
      end
    end
  end

  default clocking cb @(posedge clock iff ce); endclocking
  default disable iff (!rst_n);
  halt_entry_a: assert property (run_state == bcbm_pkg::RUN_GO && hit
    |=> halt_request && emu_running)
    else $error("match did not request halt");
  halt_hold_a: assert property (halt_request && !strobe_rise[0]
    |=> halt_request)
    else $error("halt dropped before instruction end");
  halt_release_a: assert property (halt_request && strobe_rise[0]
    |=> !halt_request && !emu_running)
    else $error("halt not released after instruction");
  forever_run_a: assert property (run_state == bcbm_pkg::RUN_GO &&
    halt_enable_setting[1:0] == 2'h0 && !abort_cmd |=> !halt_request)
    else $error("halt without enabled factor");
  and_both_a: assert property (run_state == bcbm_pkg::RUN_GO &&
    halt_enable_setting == 3'h7 && (m_hit[0] != m_hit[1]) && !abort_cmd
    |=> !halt_request)
    else $error("and halted on one register");
  launch_refused_a: assert property (!emu_running && go_cmd && cfg_bad
    |=> !emu_running && err)
    else $error("bad setup launched");
  load_warn_a: assert property (wr_commit && is_cfg_addr
    ##1 cfg_bad |=> warn)
    else $error("no warning on bad load");
  launch_keeps_a: assert property (go_cmd |=>
    $stable(bkpt_ctrl[0]) && $stable(bkpt_ctrl[1]))
    else $error("launch changed breakpoint contents");
  halt_seen_c: cover property (run_state == bcbm_pkg::RUN_GO && hit
    ##1 halt_request);
  and_seen_c: cover property (halt_enable_setting == 3'h7 && m_hit == 2'h3);
  refused_c: cover property (go_cmd && cfg_bad);
endmodule : bcbm_top

/* test/bcbm_bus_model.sv */
// bcbm_bus_model: target processor bus, one address/data cycle per call.
// assumes the matcher passes every pin through a two-flop synchroniser.
`timescale 1ns/1ps
module bcbm_bus_model (
  input wire logic clock,
  output logic [19:0] bus_ad,
  output logic [2:0] bus_status,
  output logic [1:0] bus_seg,
  output logic addr_time,
  output logic data_time,
  output logic [19:0] exec_addr,
  output logic exec_strobe,
  output logic instr_done
);
  initial begin
    {bus_ad, bus_seg, addr_time, data_time} = '0;
    {exec_addr, exec_strobe, instr_done} = '0;
    bus_status = 3'h7;
  end
  // lines set three clocks before each strobe rise and held five clocks after it
  task automatic cyc(input logic [19:0] a, input logic [2:0] s,
                     input logic [7:0] d);
    bus_ad <= a;
    bus_status <= s;
    repeat (3) @(posedge clock);
    addr_time <= 1'b1;
    repeat (5) @(posedge clock);
    addr_time <= 1'b0;
    bus_ad <= {12'h000, d};
    repeat (3) @(posedge clock);
    data_time <= 1'b1;
    repeat (5) @(posedge clock);
    data_time <= 1'b0;
    // released address lines show the inverse, never a stale copy; status goes to 3'h7
    bus_ad <= ~bus_ad;
    bus_status <= 3'h7;
  endtask : cyc
  task automatic done();
    instr_done <= 1'b1;
    repeat (4) @(posedge clock);
    instr_done <= 1'b0;
  endtask : done
  task automatic seg(input logic [1:0] g);
    bus_seg <= g;
  endtask : seg
  task automatic ex(input logic [19:0] a);
    exec_addr <= a;
    repeat (3) @(posedge clock);
    exec_strobe <= 1'b1;
    repeat (5) @(posedge clock);
    exec_strobe <= 1'b0;
    exec_addr <= ~a;
    repeat (3) @(posedge clock);
  endtask : ex
endmodule : bcbm_bus_model

/* test/testbench.sv */
// testbench: apb master and scenario tasks for bcbm_top.
// assumes the bus model drives all processor pins; ce held high.
`timescale 1ns/1ps
module testbench;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, halt_request, emu_running, e;
  logic [19:0] bus_ad, exec_addr;
  logic [2:0] bus_status;
  logic [1:0] bus_seg;
  logic addr_time, data_time, exec_strobe, instr_done;
  logic [2:0] codes [7] = '{3'h5, 3'h6, 3'h1, 3'h2, 3'h4, 3'h3, 3'h0};
  int err_total = 0;
  int tests_run = 0;
  always #12.5 clock = ~clock;
  bcbm_top u_dut (.clock, .rst_n, .ce(1'b1), .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .bus_ad, .bus_status,
    .bus_seg, .addr_time, .data_time, .exec_addr, .exec_strobe,
    .instr_done, .halt_request, .emu_running);
  bcbm_bus_model u_bus (.clock, .bus_ad, .bus_status, .bus_seg,
    .addr_time, .data_time, .exec_addr, .exec_strobe, .instr_done);
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string n, input logic [31:0] x,
                     input logic [31:0] g);
    tests_run++;
    if (g !== x) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  // one idle edge first, so psel is never driven twice in a time step
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clock);
      if (pready === 1'b1) break;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 20) begin
      err_total++;
      tally_and_finish();
    end
  endtask : apb
  task automatic go(input logic [31:0] c, r, m, h);
    apb(1'b1, 8'h00, c);
    apb(1'b1, 8'h04, r);
    apb(1'b1, 8'h14, m);
    apb(1'b1, 8'h40, h);
    apb(1'b1, 8'h48, 32'h1);
  endtask : go
  task automatic bus(input logic [19:0] a, input logic [2:0] s,
                     input logic [7:0] d, input logic h);
    u_bus.cyc(a, s, d);
    repeat (3) @(posedge clock);
    chk("halt_request", {31'h0, h}, {31'h0, halt_request});
  endtask : bus
  task automatic stop();
    u_bus.done();
    repeat (3) @(posedge clock);
    chk("halt_request", 32'h0, {31'h0, halt_request});
    chk("emu_running", 32'h0, {31'h0, emu_running});
  endtask : stop
  task automatic t_regs();
    apb(1'b0, 8'h14, 32'h0);
    chk("amask", 32'h000f_ffff, q);
    apb(1'b0, 8'h38, 32'h0);
    chk("data_cfg", 32'h00ff_0000, q);
    apb(1'b0, 8'h4c, 32'h0);
    chk("pslverr", 32'h1, {31'h0, e});
    apb(1'b1, 8'h02, 32'h1);
    chk("pslverr", 32'h1, {31'h0, e});
  endtask : t_regs
  task automatic t_ranges();
    go(32'h22, 32'h3000, 32'h0, 32'h1);
    bus(20'h02fff, 3'h5, 8'h00, 1'b0);
    bus(20'h03000, 3'h5, 8'h00, 1'b1);
    stop();
    go(32'h42, 32'h3000, 32'h0, 32'h1);
    bus(20'h03001, 3'h5, 8'h00, 1'b0);
    bus(20'h03000, 3'h5, 8'h00, 1'b1);
    stop();
    go(32'h02, 32'h3000, 32'hff, 32'h1);
    bus(20'h031ab, 3'h6, 8'h00, 1'b0);
    bus(20'h030ab, 3'h6, 8'h00, 1'b1);
    stop();
    go(32'h1082, 32'h3188, 32'h0, 32'h1);
    bus(20'h0318a, 3'h5, 8'h00, 1'b0);
    bus(20'h03189, 3'h5, 8'h00, 1'b1);
    stop();
  endtask : t_ranges
  task automatic t_status();
    for (int k = 0; k < 7; k++) begin
      go(32'h4 | (32'h1 << (16 + k)), 32'h0, 32'hf_ffff, 32'h1);
      bus(20'h01000, codes[(k + 1) % 7], 8'h00, 1'b0);
      bus(20'h01000, codes[k], 8'h00, 1'b1);
      stop();
    end
  endtask : t_status
  task automatic t_data();
    apb(1'b1, 8'h18, 32'h0000_005a);
    go(32'h08, 32'h0, 32'hf_ffff, 32'h1);
    bus(20'h00000, 3'h5, 8'h5b, 1'b0);
    bus(20'h00000, 3'h5, 8'h5a, 1'b1);
    stop();
  endtask : t_data
  task automatic t_forever();
    go(32'h02, 32'h3000, 32'h0, 32'h0);
    bus(20'h03000, 3'h5, 8'h00, 1'b0);
    chk("emu_running", 32'h1, {31'h0, emu_running});
    apb(1'b1, 8'h48, 32'h2);
    repeat (2) @(posedge clock);
    chk("halt_request", 32'h1, {31'h0, halt_request});
    stop();
  endtask : t_forever
  task automatic t_seg_exec();
    u_bus.seg(2'h1);
    go(32'h0200_0018, 32'h0, 32'hf_ffff, 32'h1);
    bus(20'h00000, 3'h5, 8'h5a, 1'b0);
    u_bus.seg(2'h2);
    bus(20'h00000, 3'h5, 8'h5a, 1'b1);
    stop();
    go(32'h1, 32'hde, 32'h0, 32'h1);
    u_bus.ex(20'h000df);
    chk("halt_request", 32'h0, {31'h0, halt_request});
    u_bus.ex(20'h000de);
    chk("halt_request", 32'h1, {31'h0, halt_request});
    stop();
  endtask : t_seg_exec
  task automatic cfg(input logic [7:0] a, input logic [31:0] d, x);
    apb(1'b1, a, d);
    apb(1'b0, 8'h44, 32'h0);
    chk("config_bad", x, {31'h0, q[4]});
  endtask : cfg
  task automatic t_cfg();
    apb(1'b1, 8'h04, 32'h0);
    apb(1'b1, 8'h08, 32'h3ff);
    cfg(8'h00, 32'h62, 32'h0);
    cfg(8'h08, 32'h400, 32'h1);
    cfg(8'h08, 32'h3ff, 32'h0);
    apb(1'b1, 8'h0c, 32'h0100_0000);
    apb(1'b1, 8'h10, 32'h10);
    cfg(8'h00, 32'h862, 32'h1);
    cfg(8'h0c, 32'h0, 32'h0);
    cfg(8'h10, 32'h400, 32'h1);
    cfg(8'h00, 32'h0a, 32'h1);
  endtask : t_cfg
  task automatic t_and();
    apb(1'b1, 8'h20, 32'h08);
    apb(1'b1, 8'h38, 32'h5a);
    go(32'h02, 32'h3000, 32'h0, 32'h7);
    bus(20'h03000, 3'h5, 8'h5b, 1'b0);
    bus(20'h03000, 3'h5, 8'h5a, 1'b1);
    stop();
    apb(1'b1, 8'h20, 32'h02);
    cfg(8'h00, 32'h08, 32'h1);
  endtask : t_and
  task automatic t_bad_and();
    apb(1'b1, 8'h44, 32'h4);
    apb(1'b1, 8'h00, 32'h1);
    apb(1'b1, 8'h40, 32'h7);
    apb(1'b0, 8'h44, 32'h0);
    chk("warn", 32'h1, {31'h0, q[2]});
    apb(1'b1, 8'h48, 32'h1);
    apb(1'b0, 8'h44, 32'h0);
    chk("err", 32'h1, {31'h0, q[3]});
    chk("running", 32'h0, {31'h0, q[0]});
  endtask : t_bad_and
  initial begin
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    t_regs();
    t_ranges();
    t_status();
    t_data();
    t_forever();
    t_seg_exec();
    t_cfg();
    t_and();
    t_bad_and();
    tally_and_finish();
  end
endmodule : testbench
